// ===== hdl/gsrf_byte_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "gsrf_params.svh"
module gsrf_byte_decode (
   input  wire logic       register_extension_prefix,
   input  wire logic [3:0] code,
   output logic      [3:0] reg_idx,
   output logic            high_byte,
   output logic            new_low
);
   // -----------------------------------------------------------
   // byte register code mapping
   // -----------------------------------------------------------
   always_comb begin
      reg_idx   = code;
      high_byte = 1'b0;
      new_low   = 1'b0;
      if (!register_extension_prefix) begin
         reg_idx   = {2'h0, code[1:0]};
         high_byte = code[2];
         if (code[3]) begin
            reg_idx   = 4'h0;
            high_byte = 1'b0;
         end
      end else begin
         new_low = code[2] | code[3];
      end
   end
endmodule
`default_nettype wire

// ===== hdl/gsrf_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "gsrf_params.svh"
module gsrf_core (
   input  wire logic                   CLK,
   input  wire logic                   RST,
   input  wire logic                   CE,
   input  wire logic                   LONG_MODE,
   input  wire logic                   REGISTER_EXTENSION_PREFIX,
   input  wire gsrf_pkg::gsrf_size_t   OP_SIZE,
   input  wire logic [3:0]             RD_A_CODE,
   input  wire logic [3:0]             RD_B_CODE,
   input  wire logic                   WR_EN,
   input  wire logic [3:0]             WR_CODE,
   input  wire logic [63:0]            WR_DATA,
   input  wire gsrf_pkg::gsrf_seg_ld_t SEG_LD,
   input  wire logic [2:0]             SEG_IDX,
   input  wire logic [15:0]            SEG_SEL,
   input  wire logic                   SEG_SEL_VALID,
   input  wire logic [2:0]             ADDR_SEG,
   input  wire logic [63:0]            ADDR_DESC_BASE,
   input  wire logic [63:0]            INSTRUCTION_OFFSET,
   output logic      [63:0]            RD_A_DATA,
   output logic      [63:0]            RD_B_DATA,
   output logic                        ACCESS_FAULT,
   output logic      [15:0]            SEG_SEL_OUT,
   output logic      [63:0]            SEG_BASE_OUT,
   output logic                        LIMIT_CHECK_EN,
   output logic      [15:0]            FETCH_SEL,
   output logic      [63:0]            FETCH_OFFSET,
   output logic                        SEG_LD_REFUSED,
   output logic      [15:0]            STACK_SEL
);
   // -----------------------------------------------------------
   // state
   // -----------------------------------------------------------
   typedef struct packed {
      logic [`GSRF_NUM_GPR-1:0][63:0]          gpr;
      logic [`GSRF_NUM_SEG-1:0][`GSRF_SEL_W-1:0] sel;
      logic                                    long_q;
      logic [63:0]                             rd_a;
      logic [63:0]                             rd_b;
      logic                                    fault;
      logic                                    refused;
   } gsrf_state_t;

   gsrf_state_t s_q;
   gsrf_state_t s_d;

   logic [3:0] a_idx, b_idx, w_idx;
   logic       a_hi, b_hi, w_hi;
   logic       a_new, b_new, w_new;

   // -----------------------------------------------------------
   // byte code decoders
   // -----------------------------------------------------------
   // one decoder per port: read a, read b, write
   logic [2:0][3:0] dec_code;
   logic [2:0][3:0] dec_idx;
   logic [2:0]      dec_hi;
   logic [2:0]      dec_new;

   assign dec_code = {WR_CODE, RD_B_CODE, RD_A_CODE};

   for (genvar g = 0; g < 3; g++) begin : g_dec
      gsrf_byte_decode u_dec (
         .register_extension_prefix       (REGISTER_EXTENSION_PREFIX),
         .code      (dec_code[g]),
         .reg_idx   (dec_idx[g]),
         .high_byte (dec_hi[g]),
         .new_low   (dec_new[g])
      );
   end

   assign {w_idx, b_idx, a_idx} = dec_idx;
   assign {w_hi, b_hi, a_hi}    = dec_hi;
   assign {w_new, b_new, a_new} = dec_new;

   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   // index used by non-byte views; upper eight need the prefix
   function automatic logic [3:0] wide_idx(input logic register_extension_prefix, input logic [3:0] c);
      wide_idx = register_extension_prefix ? c : {1'b0, c[2:0]};
   endfunction

   function automatic logic [63:0] read_view(input logic [63:0] r,
                                             input gsrf_pkg::gsrf_size_t sz,
                                             input logic hi);
      read_view = 64'h0000_0000_0000_0000;
      case (sz)
         gsrf_pkg::GSRF_SZ_8: begin
            read_view[7:0] = hi ? r[15:8] : r[7:0];
         end
         gsrf_pkg::GSRF_SZ_16: begin
            read_view[15:0] = r[15:0];
         end
         gsrf_pkg::GSRF_SZ_32: begin
            read_view[31:0] = r[31:0];
         end
         default: begin
            read_view = r;
         end
      endcase
   endfunction

   // segments whose base survives in 64-bit mode
   function automatic logic base_kept(input logic [2:0] idx);
      base_kept = (idx == `GSRF_SEG_DATA3) || (idx == `GSRF_SEG_DATA4);
   endfunction

   // -----------------------------------------------------------
   // next state
   // -----------------------------------------------------------
   gsrf_pkg::gsrf_size_t eff_size;
   logic                 size_bad;
   logic                 mix_bad;
   logic [3:0]           ra, rb, rw;
   logic                 is_byte;
   logic                 seg_ok;

   always_comb begin
      s_d      = s_q;
      // default operand size is 32; 64 only with the prefix
      size_bad = (OP_SIZE == gsrf_pkg::GSRF_SZ_64) && !REGISTER_EXTENSION_PREFIX;
      eff_size = size_bad ? gsrf_pkg::GSRF_SZ_32 : OP_SIZE;
      is_byte  = (OP_SIZE == gsrf_pkg::GSRF_SZ_8);
      // the prefix remaps high-byte codes, so a mix cannot arise by construction
      mix_bad  = is_byte &&
                 ((a_hi | b_hi | w_hi) && (a_new | b_new | w_new));
      ra = is_byte ? a_idx : wide_idx(REGISTER_EXTENSION_PREFIX, RD_A_CODE);
      rb = is_byte ? b_idx : wide_idx(REGISTER_EXTENSION_PREFIX, RD_B_CODE);
      rw = is_byte ? w_idx : wide_idx(REGISTER_EXTENSION_PREFIX, WR_CODE);
      s_d.fault = size_bad | mix_bad;

      // reads sample committed state; no same-cycle bypass
      s_d.rd_a = read_view(s_q.gpr[ra], eff_size, a_hi && is_byte);
      s_d.rd_b = read_view(s_q.gpr[rb], eff_size, b_hi && is_byte);

      s_d.long_q = LONG_MODE;
      // leaving 64-bit mode: upper halves become undefined
      if (s_q.long_q && !LONG_MODE) begin
         for (int i = 0; i < `GSRF_NUM_GPR; i++) begin
            s_d.gpr[i][63:32] = `GSRF_UNDEF_HI32;
         end
      end

      if (WR_EN && !s_d.fault) begin
         case (eff_size)
            gsrf_pkg::GSRF_SZ_64: begin
               s_d.gpr[rw] = WR_DATA;
            end
            gsrf_pkg::GSRF_SZ_32: begin
               if (LONG_MODE) begin
                  s_d.gpr[rw] = {`GSRF_ZERO_HI32, WR_DATA[31:0]};
               end else begin
                  s_d.gpr[rw][31:0] = WR_DATA[31:0];
               end
            end
            gsrf_pkg::GSRF_SZ_16: begin
               s_d.gpr[rw][15:0] = WR_DATA[15:0];
            end
            default: begin
               if (w_hi) begin
                  s_d.gpr[rw][15:8] = WR_DATA[7:0];
               end else begin
                  s_d.gpr[rw][7:0] = WR_DATA[7:0];
               end
            end
         endcase
      end

      // selector loads; legacy validity applies in every mode
      seg_ok = SEG_SEL_VALID;
      s_d.refused = 1'b0;
      case (SEG_LD)
         gsrf_pkg::GSRF_LD_MOVE: begin
            if (SEG_IDX == `GSRF_SEG_CODE || SEG_IDX > `GSRF_SEG_DATA4 || !seg_ok) begin
               s_d.refused = 1'b1;
            end else begin
               s_d.sel[SEG_IDX] = SEG_SEL;
            end
         end
         gsrf_pkg::GSRF_LD_XFER: begin
            if (SEG_IDX > `GSRF_SEG_DATA4 || !seg_ok) begin
               s_d.refused = 1'b1;
            end else begin
               s_d.sel[SEG_IDX] = SEG_SEL;
            end
         end
         default: begin
            s_d.refused = 1'b0;
         end
      endcase
   end

   // -----------------------------------------------------------
   // registers
   // -----------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         for (int i = 0; i < `GSRF_NUM_GPR; i++) begin
            s_q.gpr[i] <= `GSRF_GPR_RST;
         end
         for (int j = 0; j < `GSRF_NUM_SEG; j++) begin
            s_q.sel[j] <= `GSRF_SEL_RST;
         end
         s_q.long_q  <= 1'b0;
         s_q.rd_a    <= `GSRF_GPR_RST;
         s_q.rd_b    <= `GSRF_GPR_RST;
         s_q.fault   <= 1'b0;
         s_q.refused <= 1'b0;
      end else if (CE) begin
         s_q <= s_d;
      end
   end

   // -----------------------------------------------------------
   // outputs
   // -----------------------------------------------------------
   logic [2:0] aseg;
   assign aseg = (ADDR_SEG > `GSRF_SEG_DATA4) ? `GSRF_SEG_DATA1 : ADDR_SEG;

   assign RD_A_DATA      = s_q.rd_a;
   assign RD_B_DATA      = s_q.rd_b;
   assign ACCESS_FAULT   = s_q.fault;
   assign SEG_LD_REFUSED = s_q.refused;
   assign SEG_SEL_OUT    = s_q.sel[aseg];
   // flat model in 64-bit mode except the two extra data segments
   assign SEG_BASE_OUT   = (s_q.long_q && !base_kept(aseg)) ?
                           `GSRF_ZERO_BASE : ADDR_DESC_BASE;
   assign LIMIT_CHECK_EN = !s_q.long_q;
   assign FETCH_SEL      = s_q.sel[`GSRF_SEG_CODE];
   assign FETCH_OFFSET   = INSTRUCTION_OFFSET;
   assign STACK_SEL      = s_q.sel[`GSRF_SEG_STACK];
endmodule
`default_nettype wire

// ===== hdl/gsrf_params.svh
`ifndef GSRF_PARAMS_SVH
`define GSRF_PARAMS_SVH
// ------------------------------------------------------------
// register counts and widths
// ------------------------------------------------------------
`define GSRF_NUM_GPR        16
`define GSRF_NUM_LEGACY_GPR 8
`define GSRF_NUM_SEG        6
`define GSRF_SEL_W          16
// ------------------------------------------------------------
// segment register indices
// ------------------------------------------------------------
`define GSRF_SEG_CODE    3'h0
`define GSRF_SEG_STACK   3'h1
`define GSRF_SEG_DATA1   3'h2
`define GSRF_SEG_DATA2   3'h3
`define GSRF_SEG_DATA3   3'h4
`define GSRF_SEG_DATA4   3'h5
// ------------------------------------------------------------
// reset values and zero constants
// ------------------------------------------------------------
`define GSRF_GPR_RST     64'h0000_0000_0000_0000
`define GSRF_SEL_RST     16'h0000
`define GSRF_ZERO_BASE   64'h0000_0000_0000_0000
`define GSRF_ZERO_HI32   32'h0000_0000
// ------------------------------------------------------------
// upper-half value left after leaving 64-bit mode (undefined)
// ------------------------------------------------------------
`define GSRF_UNDEF_HI32  32'h0000_0000
`endif

// ===== hdl/gsrf_pkg.sv
package gsrf_pkg;
   typedef enum logic [1:0] {
      GSRF_SZ_8  = 2'h0,
      GSRF_SZ_16 = 2'h1,
      GSRF_SZ_32 = 2'h2,
      GSRF_SZ_64 = 2'h3
   } gsrf_size_t;

   typedef enum logic [1:0] {
      GSRF_LD_NONE  = 2'h0,
      GSRF_LD_MOVE  = 2'h1,
      GSRF_LD_XFER  = 2'h2
   } gsrf_seg_ld_t;

   typedef enum logic [1:0] {
      GSRF_MD_LEGACY = 2'h0,
      GSRF_MD_LONG   = 2'h1,
      GSRF_MD_SCRUB  = 2'h3
   } gsrf_mode_st_t;
endpackage

// ===== verif/gsrf_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module gsrf_core_properties (
   input wire logic                   CLK,
   input wire logic                   RST,
   input wire logic                   CE,
   input wire logic                   LONG_MODE,
   input wire logic                   REGISTER_EXTENSION_PREFIX,
   input wire gsrf_pkg::gsrf_size_t   OP_SIZE,
   input wire gsrf_pkg::gsrf_seg_ld_t SEG_LD,
   input wire logic [2:0]             SEG_IDX,
   input wire logic [15:0]            SEG_SEL,
   input wire logic                   SEG_SEL_VALID,
   input wire logic [2:0]             ADDR_SEG,
   input wire logic [63:0]            ADDR_DESC_BASE,
   input wire logic [63:0]            INSTRUCTION_OFFSET,
   input wire logic                   ACCESS_FAULT,
   input wire logic [63:0]            SEG_BASE_OUT,
   input wire logic                   LIMIT_CHECK_EN,
   input wire logic [15:0]            FETCH_SEL,
   input wire logic [63:0]            FETCH_OFFSET,
   input wire logic                   SEG_LD_REFUSED,
   input wire logic [15:0]            STACK_SEL
);
   // ------------------------------
   // checks, reset masks them all
   // ------------------------------
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);
   no_prefix_fault_a:
      assert property (CE && OP_SIZE == gsrf_pkg::GSRF_SZ_64 && !REGISTER_EXTENSION_PREFIX
         |=> ACCESS_FAULT) else $error("wide request without prefix not faulted");
   narrow_no_fault_a:
      assert property (CE && OP_SIZE != gsrf_pkg::GSRF_SZ_64 |=> !ACCESS_FAULT)
         else $error("narrow request faulted");
   code_move_refused_a:
      assert property (CE && SEG_LD == gsrf_pkg::GSRF_LD_MOVE && SEG_IDX == 3'h0
         |=> SEG_LD_REFUSED && $stable(FETCH_SEL)) else $error("code move load taken");
   stack_move_taken_a:
      assert property (CE && SEG_LD == gsrf_pkg::GSRF_LD_MOVE && SEG_IDX == 3'h1 && SEG_SEL_VALID
         |=> !SEG_LD_REFUSED && STACK_SEL == $past(SEG_SEL)) else $error("stack load lost");
   bad_sel_refused_a:
      assert property (CE && SEG_LD != gsrf_pkg::GSRF_LD_NONE && !SEG_SEL_VALID
         |=> SEG_LD_REFUSED && $stable(STACK_SEL)) else $error("invalid selector taken");
   fetch_pair_a:
      assert property (FETCH_OFFSET == INSTRUCTION_OFFSET) else $error("fetch offset differs");
   limit_off_a:
      assert property (CE && LONG_MODE |=> !LIMIT_CHECK_EN) else $error("limit check on");
   flat_base_a:
      assert property (!LIMIT_CHECK_EN && ADDR_SEG < 3'h4 |-> SEG_BASE_OUT == '0)
         else $error("flat segment base not zero");
   extra_base_a:
      assert property (!LIMIT_CHECK_EN && ADDR_SEG inside {3'h4, 3'h5}
         |-> SEG_BASE_OUT == ADDR_DESC_BASE) else $error("extra data base lost");
endmodule
bind gsrf_core gsrf_core_properties chk (.CLK(CLK), .RST(RST), .CE(CE), .LONG_MODE(LONG_MODE),
   .REGISTER_EXTENSION_PREFIX(REGISTER_EXTENSION_PREFIX), .OP_SIZE(OP_SIZE), .SEG_LD(SEG_LD),
   .SEG_IDX(SEG_IDX), .SEG_SEL(SEG_SEL), .SEG_SEL_VALID(SEG_SEL_VALID), .ADDR_SEG(ADDR_SEG),
   .ADDR_DESC_BASE(ADDR_DESC_BASE), .INSTRUCTION_OFFSET(INSTRUCTION_OFFSET),
   .ACCESS_FAULT(ACCESS_FAULT), .SEG_BASE_OUT(SEG_BASE_OUT), .LIMIT_CHECK_EN(LIMIT_CHECK_EN),
   .FETCH_SEL(FETCH_SEL), .FETCH_OFFSET(FETCH_OFFSET), .SEG_LD_REFUSED(SEG_LD_REFUSED),
   .STACK_SEL(STACK_SEL));
`default_nettype wire

// ===== verif/gsrf_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gsrf_core_tb;
   logic                   clk = 1'b0;
   logic                   rst = 1'b1;
   logic                   ce = 1'b1;
   logic                   long_mode = 1'b1;
   logic                   prefix = 1'b0;
   logic                   wr_en = 1'b0;
   logic [3:0]             code = 4'h0;
   logic [63:0]            wr_data = '0;
   logic [2:0]             seg_idx = 3'h0;
   logic [2:0]             addr_seg = 3'h0;
   logic [15:0]            seg_sel = 16'h0000;
   gsrf_pkg::gsrf_size_t   op_size = gsrf_pkg::GSRF_SZ_32;
   gsrf_pkg::gsrf_seg_ld_t seg_ld = gsrf_pkg::GSRF_LD_NONE;
   logic                   sel_valid, fault, limit_en, refused, flt_v, ref_v;
   logic [63:0]            desc_base, ioff, rd_a, base_out, rd_v;
   logic [63:0]            rd_b, rdb_v, fetch_off;
   logic [15:0]            sel_out, fetch_sel, stack_sel;
   int                     miscompares = 0;
   int                     checked = 0;
   gsrf_core dut (.CLK(clk), .RST(rst), .CE(ce), .LONG_MODE(long_mode),
      .REGISTER_EXTENSION_PREFIX(prefix), .OP_SIZE(op_size), .RD_A_CODE(code),
      .RD_B_CODE(code), .WR_EN(wr_en), .WR_CODE(code), .WR_DATA(wr_data), .SEG_LD(seg_ld),
      .SEG_IDX(seg_idx), .SEG_SEL(seg_sel), .SEG_SEL_VALID(sel_valid), .ADDR_SEG(addr_seg),
      .ADDR_DESC_BASE(desc_base), .INSTRUCTION_OFFSET(ioff), .RD_A_DATA(rd_a), .RD_B_DATA(rd_b),
      .ACCESS_FAULT(fault), .SEG_SEL_OUT(sel_out), .SEG_BASE_OUT(base_out),
      .LIMIT_CHECK_EN(limit_en), .FETCH_SEL(fetch_sel), .FETCH_OFFSET(fetch_off),
      .SEG_LD_REFUSED(refused), .STACK_SEL(stack_sel));
   gsrf_datapath_model far (.clk(clk), .rst(rst), .ce(ce), .seg_sel(seg_sel),
      .addr_seg(addr_seg), .sel_valid(sel_valid), .desc_base(desc_base), .offset(ioff));
   always #5 clk = ~clk;
   // ------------------------------
   // shared tasks
   // ------------------------------
   // answers of the previous request, taken once settled
   task automatic step;
      #1;
      rd_v = rd_a;
      rdb_v = rd_b;
      flt_v = fault;
      ref_v = refused;
      @(posedge clk);
   endtask
   task automatic req(input logic we, input logic [1:0] sz, input logic px,
                      input logic [3:0] c, input logic [63:0] d);
      wr_en <= we;
      op_size <= gsrf_pkg::gsrf_size_t'(sz);
      prefix <= px;
      code <= c;
      wr_data <= d;
      seg_ld <= gsrf_pkg::GSRF_LD_NONE;
      step();
   endtask
   task automatic seg(input logic [1:0] ld, input logic [2:0] i, input logic [15:0] s);
      wr_en <= 1'b0;
      seg_ld <= gsrf_pkg::gsrf_seg_ld_t'(ld);
      seg_idx <= i;
      seg_sel <= s;
      step();
   endtask
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      if (miscompares == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_sizes;
      req(1'b1, 2'h3, 1'b1, 4'h9, 64'h0123_4567_89ab_cdef);
      req(1'b0, 2'h3, 1'b1, 4'h9, '0);
      req(1'b1, 2'h2, 1'b1, 4'h9, 64'hffff_ffff_8765_4321);
      cmp(rd_v, 64'h0123_4567_89ab_cdef);
      cmp(rdb_v, 64'h0123_4567_89ab_cdef);
      req(1'b0, 2'h3, 1'b1, 4'h9, '0);
      req(1'b1, 2'h1, 1'b1, 4'h9, 64'haaaa_aaaa_aaaa_5a5a);
      cmp(rd_v, 64'h0000_0000_8765_4321);
      req(1'b1, 2'h0, 1'b1, 4'h9, 64'hbbbb_bbbb_bbbb_bbc3);
      req(1'b0, 2'h3, 1'b1, 4'h9, '0);
      req(1'b0, 2'h1, 1'b1, 4'h9, '0);
      cmp(rd_v, 64'h0000_0000_8765_5ac3);
      req(1'b0, 2'h0, 1'b1, 4'h9, '0);
      cmp(rd_v, 64'h5ac3);
      req(1'b0, 2'h2, 1'b0, 4'h0, '0);
      cmp(rd_v, 64'hc3);
   endtask
   task automatic t_prefix;
      req(1'b1, 2'h3, 1'b0, 4'h2, 64'hffff_ffff_ffff_ffff);
      req(1'b0, 2'h3, 1'b1, 4'h2, '0);
      cmp(64'(flt_v), 64'h1);
      req(1'b1, 2'h0, 1'b0, 4'h4, 64'h77);
      cmp(rd_v, 64'h0);
      req(1'b1, 2'h0, 1'b1, 4'h4, 64'h44);
      req(1'b0, 2'h3, 1'b1, 4'h0, '0);
      cmp(64'(flt_v), 64'h0);
      req(1'b0, 2'h3, 1'b1, 4'h4, '0);
      req(1'b0, 2'h2, 1'b0, 4'h0, '0);
      cmp(rd_v, 64'h44);
      req(1'b0, 2'h2, 1'b0, 4'h0, '0);
      cmp(rd_v, 64'h7700);
   endtask
   task automatic t_seg;
      logic [15:0] es;
      seg(2'h1, 3'h0, 16'h0010);
      seg(2'h2, 3'h0, 16'h0028);
      cmp(64'(ref_v), 64'h1);
      seg(2'h1, 3'h1, 16'h0033);
      cmp(64'(ref_v), 64'h0);
      for (int i = 2; i < 6; i++) begin
         seg(2'h1, 3'(i), 16'h0040 + 16'(i));
      end
      seg(2'h1, 3'h1, 16'h0002);
      seg(2'h0, 3'h0, 16'h0000);
      cmp(64'(ref_v), 64'h1);
      for (int i = 0; i < 6; i++) begin
         addr_seg <= 3'(i);
         #1;
         es = (i == 0) ? 16'h0028 : (i == 1) ? 16'h0033 : 16'h0040 + 16'(i);
         cmp(64'(sel_out), 64'(es));
         cmp(64'(fetch_sel), 64'h0028);
         cmp(fetch_off, ioff);
         cmp(64'(stack_sel), 64'h0033);
         cmp(base_out, (i > 3) ? {5'h00, 3'(i), 56'h00_0000_0000_1000} : '0);
         cmp(64'(limit_en), 64'h0);
         @(posedge clk);
      end
   endtask
   // upper halves chosen to read back as zero
   task automatic t_exit;
      req(1'b1, 2'h3, 1'b1, 4'h5, 64'hffff_ffff_ffff_ffff);
      long_mode <= 1'b0;
      req(1'b0, 2'h2, 1'b0, 4'h0, '0);
      long_mode <= 1'b1;
      req(1'b0, 2'h2, 1'b0, 4'h0, '0);
      req(1'b0, 2'h3, 1'b1, 4'h5, '0);
      req(1'b0, 2'h2, 1'b0, 4'h0, '0);
      cmp(rd_v, 64'h0000_0000_ffff_ffff);
   endtask
   // a write offered while the enable is low must not land
   task automatic t_hold;
      ce <= 1'b0;
      req(1'b1, 2'h3, 1'b1, 4'h5, 64'h1234_5678_9abc_def0);
      ce <= 1'b1;
      req(1'b0, 2'h3, 1'b1, 4'h5, '0);
      req(1'b0, 2'h2, 1'b0, 4'h0, '0);
      cmp(rd_v, 64'h0000_0000_ffff_ffff);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_sizes();
      t_prefix();
      t_seg();
      t_exit();
      t_hold();
      stop_test();
   end
   // whole run needs well under 200 cycles
   initial begin
      repeat (600) @(posedge clk);
      miscompares++;
      stop_test();
   end
endmodule
`default_nettype wire

// ===== verif/gsrf_datapath_model.sv
`timescale 1ns/1ps
`default_nettype none
module gsrf_datapath_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [15:0] seg_sel,
   input  wire logic [2:0]  addr_seg,
   output logic             sel_valid,
   output logic      [63:0] desc_base,
   output logic      [63:0] offset
);
   // null selector fails the legacy check
   assign sel_valid = (seg_sel[15:2] != 14'h0000);
   // nonzero base per segment, so a forced zero shows
   assign desc_base = {5'h00, addr_seg, 56'h00_0000_0000_1000};
   always_ff @(posedge clk) begin
      if (rst) begin
         offset <= '0;
      end else if (ce) begin
         offset <= offset + 64'h4;
      end
   end
endmodule
`default_nettype wire
